// ### rtl/lpc_pkg.sv
// Constants shared by the LED pump and PWM control block.
// Assumes a single 100 MHz system clock.
package lpc_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_ENABLE = 8'h00;
	localparam logic [7:0] REG_PWM_R = 8'h02;
	localparam logic [7:0] REG_PWM_G = 8'h03;
	localparam logic [7:0] REG_PWM_B = 8'h04;
	localparam logic [7:0] REG_CURRENT_R = 8'h05;
	localparam logic [7:0] REG_CURRENT_G = 8'h06;
	localparam logic [7:0] REG_CURRENT_B = 8'h07;
	localparam logic [7:0] REG_CONFIG = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	// ----------------------------------------------------------------
	// Field positions and encodings
	// ----------------------------------------------------------------
	localparam int LOG_CURVE_BIT = 7;
	localparam int PWM_FAST_BIT = 6;
	localparam int GAIN_SEL_HI = 4;
	localparam int GAIN_SEL_LO = 3;
	localparam int RED_SUPPLY_BIT = 2;
	localparam logic [1:0] GAIN_OFF = 2'h0;
	localparam logic [1:0] GAIN_1X = 2'h1;
	localparam logic [1:0] GAIN_1P5X = 2'h2;
	localparam logic [1:0] GAIN_AUTO = 2'h3;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] PWM_RST = 8'h00;
	localparam logic [7:0] CURRENT_RST = 8'hAF;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int PWM_STEPS = 256;
	localparam int PWM_SLOW_HZ = 256;
	localparam int PWM_FAST_HZ = 558;
	localparam logic [10:0] PWM_SLOW_DIV = 11'(CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS));
	localparam logic [10:0] PWM_FAST_DIV = 11'(CLK_HZ / (PWM_FAST_HZ * PWM_STEPS));
	localparam int IDLE_MS = 50;
	localparam int IDLE_CYCLES = CLK_HZ / 1000 * IDLE_MS;
	localparam int FILTER_US = 20;
	localparam int FILTER_CYCLES = CLK_HZ / 1_000_000 * FILTER_US;
	localparam logic [6:0] DEV_ADDR_BASE = 7'h30;
endpackage

// ### rtl/lpc_reg_if.sv
// Register access path between the serial slave and the register file.
// Both ends run on sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface lpc_reg_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave (output wr_en, output addr, output wdata, input rdata);
	modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### rtl/lpc_gain_ctrl.sv
// Charge pump gain controller with headroom filtering and idle timeout.
// Inputs are already synchronised to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module lpc_gain_ctrl #(
	parameter int IDLE_LIMIT = lpc_pkg::IDLE_CYCLES,
	parameter int FILTER_LIMIT = lpc_pkg::FILTER_CYCLES
) (
	input wire logic sys_clk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [1:0] gain_sel, // Pump gain select field.
	input wire logic red_to_supply, // Red source on the supply.
	input wire logic [2:0] low_headroom, // Driver lacks headroom, per output.
	input wire logic [2:0] supply_ok, // Supply alone suffices, per output.
	input wire logic leds_active, // Any output is lit.
	output logic pump_enable, // Pump running.
	output logic pump_boost // Pump at 1.5x.
);
	import lpc_pkg::*;

	initial begin
		if (IDLE_LIMIT < 1 || FILTER_LIMIT < 1) begin
			$error("lpc_gain_ctrl: limits must be positive");
		end
	end

	typedef enum logic {GS_BYPASS, GS_BOOST} lpc_gstate_t;

	function automatic logic [31:0] filt_step(input logic raw, input logic [31:0] cnt);
		if (!raw) begin
			filt_step = 32'h0;
		end else if (cnt == 32'(FILTER_LIMIT)) begin
			filt_step = cnt;
		end else begin
			filt_step = cnt + 32'h1;
		end
	endfunction

	lpc_gstate_t gstate;
	lpc_gstate_t next_gstate;
	logic [31:0] up_cnt;
	logic [31:0] down_cnt;
	logic [31:0] idle_cnt;

	wire logic [2:0] mon_mask = red_to_supply ? 3'h6 : 3'h7;
	wire logic want_up = |(low_headroom & mon_mask);
	wire logic want_down = &(supply_ok | ~mon_mask);
	wire logic up_f = (up_cnt == 32'(FILTER_LIMIT));
	wire logic down_f = (down_cnt == 32'(FILTER_LIMIT));
	wire logic idle = (idle_cnt == 32'(IDLE_LIMIT));
	wire logic auto_mode = (gain_sel == GAIN_AUTO);

	always_comb begin
		next_gstate = gstate;
		case (gstate)
			GS_BYPASS: begin
				if (up_f && !idle) begin
					next_gstate = GS_BOOST;
				end
			end
			GS_BOOST: begin
				if (idle || down_f) begin
					next_gstate = GS_BYPASS;
				end
			end
			default: next_gstate = GS_BYPASS;
		endcase
		if (!auto_mode) begin
			next_gstate = GS_BYPASS;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gstate <= GS_BYPASS;
			up_cnt <= 32'h0;
			down_cnt <= 32'h0;
			idle_cnt <= 32'h0;
			pump_enable <= 1'b0;
			pump_boost <= 1'b0;
		end else begin
			gstate <= next_gstate;
			up_cnt <= filt_step(want_up && auto_mode, up_cnt);
			down_cnt <= filt_step(want_down && auto_mode, down_cnt);
			idle_cnt <= leds_active ? 32'h0 : (idle ? idle_cnt : idle_cnt + 32'h1);
			pump_enable <= (gain_sel != GAIN_OFF);
			pump_boost <= (gain_sel == GAIN_1P5X) || (next_gstate == GS_BOOST);
		end
	end
endmodule
`default_nettype wire

// ### rtl/lpc_i2c_slave.sv
// Two-wire serial register slave: pointer byte, then data, auto increment.
// Pins arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module lpc_i2c_slave (
	input wire logic sys_clk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [6:0] dev_addr, // Own bus address.
	input wire logic scl_in, // Serial clock pin.
	input wire logic sda_in, // Serial data pin level.
	output logic sda_out, // Serial data drive value.
	output logic sda_oe_n, // Data drive enable, active low.
	lpc_reg_if.slave rbus // Register access.
);
	typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_PTR, SL_WR, SL_ACK, SL_RD, SL_RACK} lpc_sl_t;

	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	lpc_sl_t state;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic [7:0] ptr;
	logic is_read;
	logic ptr_next;
	logic drive;

	wire logic scl_s = scl_sync[1];
	wire logic sda_s = sda_sync[1];
	wire logic start = scl_s && scl_q && sda_q && !sda_s;
	wire logic stop = scl_s && scl_q && !sda_q && sda_s;
	wire logic rise = scl_s && !scl_q;
	wire logic fall = !scl_s && scl_q;
	wire logic rx_state = (state == SL_ADDR) || (state == SL_PTR) || (state == SL_WR);

	assign sda_out = 1'b0;
	assign sda_oe_n = !drive;
	assign rbus.addr = ptr;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SL_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 8'h00;
			is_read <= 1'b0;
			ptr_next <= 1'b0;
			drive <= 1'b0;
			rbus.wr_en <= 1'b0;
			rbus.wdata <= 8'h00;
		end else begin
			rbus.wr_en <= 1'b0;
			// Advance the pointer only after the register file has used it for the write.
			if (rbus.wr_en) begin
				ptr <= ptr + 8'h01;
			end
			if (start) begin
				state <= SL_ADDR;
				bitcnt <= 4'h0;
				drive <= 1'b0;
			end else if (stop) begin
				state <= SL_IDLE;
				drive <= 1'b0;
			end else if (rise && rx_state && bitcnt != 4'h8) begin
				shreg <= {shreg[6:0], sda_s};
				bitcnt <= bitcnt + 4'h1;
			end else if (rise && state == SL_RACK) begin
				state <= sda_s ? SL_IDLE : SL_ACK;
			end else if (fall && rx_state && bitcnt == 4'h8) begin
				drive <= 1'b1;
				state <= SL_ACK;
				if (state == SL_ADDR) begin
					is_read <= shreg[0];
					ptr_next <= !shreg[0];
					if (shreg[7:1] != dev_addr) begin
						drive <= 1'b0;
						state <= SL_IDLE;
					end
				end else if (state == SL_PTR) begin
					ptr <= shreg;
				end else begin
					rbus.wr_en <= 1'b1;
					rbus.wdata <= shreg;
				end
			end else if (fall && state == SL_ACK) begin
				bitcnt <= 4'h0;
				drive <= 1'b0;
				if (is_read) begin
					shreg <= rbus.rdata;
					drive <= !rbus.rdata[7];
					ptr <= ptr + 8'h01;
					state <= SL_RD;
				end else begin
					state <= ptr_next ? SL_PTR : SL_WR;
					ptr_next <= 1'b0;
				end
			end else if (rise && state == SL_RD) begin
				bitcnt <= bitcnt + 4'h1;
			end else if (fall && state == SL_RD) begin
				if (bitcnt == 4'h8) begin
					drive <= 1'b0;
					state <= SL_RACK;
				end else begin
					shreg <= {shreg[6:0], 1'b0};
					drive <= !shreg[6];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/lpc_top.sv
// Top of the LED pump gain and PWM control block.
// Assumes a 100 MHz sys_clk; all pins are asynchronous to it.
// Functional notes
// - Gain field 00 off, 01 forced 1x, 10 forced 1.5x, 11 automatic.
// - Automatic mode raises gain to 1.5x when any monitored driver lacks headroom.
// - Automatic mode returns to 1x once supply alone keeps all monitored drivers unsaturated.
// - Automatic mode falls back to bypass after outputs idle over 50 ms.
// - Headroom indications are digitally filtered before changing gain.
// - Red to supply set means red headroom is ignored; green and blue still watched.
// - Red source bit resets to 0 (pump); 1 puts red on supply.
// - Each channel has an 8-bit current code, 0.1 mA steps, 25.5 mA maximum.
// - Each channel modulates its current with an 8-bit PWM duty.
// - PWM runs at 256 Hz with rate bit 0, 558 Hz with 1.
// - Dimming curve bit selects linear (0) or logarithmic (1) duty mapping.
// - Dimming curve bit is bit 7 of the enable register.
// - PWM rate bit is bit 6 of the configuration register.
`timescale 1ns/100ps
`default_nettype none
module lpc_top #(
	parameter int IDLE_LIMIT = lpc_pkg::IDLE_CYCLES,
	parameter int FILTER_LIMIT = lpc_pkg::FILTER_CYCLES
) (
	input wire logic sys_clk, // System clock, 100 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic scl_in, // Serial clock pin.
	input wire logic sda_in, // Serial data pin level.
	output logic sda_out, // Serial data drive value.
	output logic sda_oe_n, // Serial data drive enable, active low.
	input wire logic [1:0] addr_sel, // Address select straps.
	input wire logic [2:0] low_headroom, // Saturation monitor, bit 0 red.
	input wire logic [2:0] supply_ok, // Supply sufficient, bit 0 red.
	output logic [2:0] led_pwm, // PWM gate per output, bit 0 red.
	output logic [7:0] led_current [3], // Current code per output.
	output logic pump_enable, // Charge pump on.
	output logic pump_boost, // Charge pump at 1.5x.
	output logic red_on_supply // Red source switched to supply.
);
	import lpc_pkg::*;

	initial begin
		if (IDLE_LIMIT < 1 || FILTER_LIMIT < 1) begin
			$error("lpc_top: limits must be positive");
		end
	end

	// ----------------------------------------------------------------
	// Logarithmic duty mapping
	// ----------------------------------------------------------------
	// Exponent in the top three bits, mantissa below, zero kept dark.
	function automatic logic [7:0] log_map(input logic [7:0] d);
		logic [12:0] v;
		v = 13'({8'h01, d[4:0]}) << d[7:5];
		log_map = (d == 8'h00) ? 8'h00 : v[12:5];
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] enable_reg;
	logic [7:0] config_reg;
	logic [7:0] pwm_reg [3];
	logic [7:0] current_reg [3];
	logic [1:0] addr_s1;
	logic [1:0] addr_s2;
	logic [2:0] hr_s1;
	logic [2:0] hr_s2;
	logic [2:0] ok_s1;
	logic [2:0] ok_s2;

	lpc_reg_if rif();

	lpc_i2c_slave u_slave (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.dev_addr({DEV_ADDR_BASE[6:2], addr_s2}),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.rbus(rif.slave)
	);

	wire logic log_curve = enable_reg[LOG_CURVE_BIT];
	wire logic pwm_fast = config_reg[PWM_FAST_BIT];
	wire logic [1:0] gain_select = config_reg[GAIN_SEL_HI:GAIN_SEL_LO];
	wire logic red_source_to_supply = config_reg[RED_SUPPLY_BIT];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_s1 <= 2'h0;
			addr_s2 <= 2'h0;
			hr_s1 <= 3'h0;
			hr_s2 <= 3'h0;
			ok_s1 <= 3'h0;
			ok_s2 <= 3'h0;
		end else begin
			addr_s1 <= addr_sel;
			addr_s2 <= addr_s1;
			hr_s1 <= low_headroom;
			hr_s2 <= hr_s1;
			ok_s1 <= supply_ok;
			ok_s2 <= ok_s1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= ENABLE_RST;
			config_reg <= CONFIG_RST;
			for (int c = 0; c < 3; c++) begin
				pwm_reg[c] <= PWM_RST;
				current_reg[c] <= CURRENT_RST;
			end
		end else if (rif.wr_en) begin
			case (rif.addr)
				REG_ENABLE: enable_reg <= rif.wdata;
				REG_CONFIG: config_reg <= rif.wdata;
				REG_PWM_R: pwm_reg[0] <= rif.wdata;
				REG_PWM_G: pwm_reg[1] <= rif.wdata;
				REG_PWM_B: pwm_reg[2] <= rif.wdata;
				REG_CURRENT_R: current_reg[0] <= rif.wdata;
				REG_CURRENT_G: current_reg[1] <= rif.wdata;
				REG_CURRENT_B: current_reg[2] <= rif.wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	wire logic [7:0] status_val = {6'h00, pump_boost, pump_enable};

	always_comb begin
		case (rif.addr)
			REG_ENABLE: rif.rdata = enable_reg;
			REG_CONFIG: rif.rdata = config_reg;
			REG_PWM_R: rif.rdata = pwm_reg[0];
			REG_PWM_G: rif.rdata = pwm_reg[1];
			REG_PWM_B: rif.rdata = pwm_reg[2];
			REG_CURRENT_R: rif.rdata = current_reg[0];
			REG_CURRENT_G: rif.rdata = current_reg[1];
			REG_CURRENT_B: rif.rdata = current_reg[2];
			REG_STATUS: rif.rdata = status_val;
			default: rif.rdata = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// PWM timebase
	// ----------------------------------------------------------------
	logic [10:0] div_cnt;
	logic [7:0] pwm_cnt;
	wire logic [10:0] div_last = (pwm_fast ? PWM_FAST_DIV : PWM_SLOW_DIV) - 11'h001;
	wire logic pwm_tick = (div_cnt >= div_last);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 11'h000;
			pwm_cnt <= 8'h00;
		end else if (pwm_tick) begin
			div_cnt <= 11'h000;
			pwm_cnt <= pwm_cnt + 8'h01;
		end else begin
			div_cnt <= div_cnt + 11'h001;
		end
	end

	// ----------------------------------------------------------------
	// Channel outputs
	// ----------------------------------------------------------------
	logic [7:0] duty_eff [3];
	logic [2:0] next_pwm;
	logic [2:0] ch_lit;

	for (genvar c = 0; c < 3; c++) begin : g_ch
		assign duty_eff[c] = log_curve ? log_map(pwm_reg[c]) : pwm_reg[c];
		assign next_pwm[c] = (duty_eff[c] > pwm_cnt);
		assign ch_lit[c] = (duty_eff[c] != 8'h00) && (current_reg[c] != 8'h00);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_pwm <= 3'h0;
			red_on_supply <= 1'b0;
			for (int c = 0; c < 3; c++) begin
				led_current[c] <= CURRENT_RST;
			end
		end else begin
			led_pwm <= next_pwm;
			red_on_supply <= red_source_to_supply;
			for (int c = 0; c < 3; c++) begin
				led_current[c] <= current_reg[c];
			end
		end
	end

	// ----------------------------------------------------------------
	// Pump gain control
	// ----------------------------------------------------------------
	lpc_gain_ctrl #(
		.IDLE_LIMIT(IDLE_LIMIT),
		.FILTER_LIMIT(FILTER_LIMIT)
	) u_gain (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.gain_sel(gain_select),
		.red_to_supply(red_source_to_supply),
		.low_headroom(hr_s2),
		.supply_ok(ok_s2),
		.leds_active(|ch_lit),
		.pump_enable(pump_enable),
		.pump_boost(pump_boost)
	);
endmodule
`default_nettype wire

// ### bench/lpc_led_model.sv
// Far-side model of the three LED outputs and their saturation monitors.
// Assumes the bench says per output whether its LED needs more than the supply.
`timescale 1ns/100ps
`default_nettype none
module lpc_led_model (
	input wire logic [2:0] need, // LED forward voltage above supply.
	input wire logic pump_boost, // Pump at 1.5x.
	output logic [2:0] low_headroom, // Driver saturating.
	output logic [2:0] supply_ok // Supply alone suffices.
);
	// A boosted pump clears saturation, but the supply still falls short.
	assign low_headroom = need & {3{~pump_boost}};
	assign supply_ok = ~need;
endmodule
`default_nettype wire

// ### bench/lpc_top_chk.sv
// Assertion checker for the LED pump and PWM control top level.
// Assumes one clock and a serial master that parks SCL high when idle.
`timescale 1ns/100ps
`default_nettype none
module lpc_top_chk #(
	parameter int IDLE_LIMIT = 200,
	parameter int FILTER_LIMIT = 8
) (
	input wire logic sys_clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic scl_in, // Serial clock.
	input wire logic sda_out, // Data drive value.
	input wire logic sda_oe_n, // Data drive enable, active low.
	input wire logic [2:0] low_headroom, // Saturation flags.
	input wire logic [2:0] supply_ok, // Supply flags.
	input wire logic [2:0] led_pwm, // PWM gates.
	input wire logic [7:0] led_current [3], // Current codes.
	input wire logic pump_enable, // Pump on.
	input wire logic pump_boost, // Pump at 1.5x.
	input wire logic red_on_supply // Red on supply.
);
	// ------------------------------------------------------------
	// Run lengths
	// ------------------------------------------------------------
	// A long SCL high means no register write can land, so changes come from the monitors.
	logic [31:0] scl_hi, hr_run, mhr_run, ok_run, dark_run;
	wire logic quiet;
	wire logic [2:0] watched;
	assign watched = {2'b11, ~red_on_supply};
	assign quiet = scl_hi >= 32'd12;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_hi <= '0;
			hr_run <= '0;
			mhr_run <= '0;
			ok_run <= '0;
			dark_run <= '0;
		end else begin
			scl_hi <= scl_in ? scl_hi + 32'd1 : '0;
			hr_run <= (low_headroom != 3'h0) ? hr_run + 32'd1 : '0;
			mhr_run <= ((low_headroom & watched) != 3'h0) ? mhr_run + 32'd1 : '0;
			ok_run <= ((supply_ok | ~watched) == 3'h7) ? ok_run + 32'd1 : '0;
			dark_run <= (led_pwm == 3'h0) ? dark_run + 32'd1 : '0;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	property p_boost_on; pump_boost |-> pump_enable; endproperty
	a_boost_on: assert property (p_boost_on) else $error("boost while pump off");
	property p_enable_hold; quiet |-> $stable(pump_enable); endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("pump enable moved");
	property p_red_hold; quiet |-> $stable(red_on_supply); endproperty
	a_red_hold: assert property (p_red_hold) else $error("red source moved");
	property p_cur_hold;
		quiet |-> $stable({led_current[0], led_current[1], led_current[2]});
	endproperty
	a_cur_hold: assert property (p_cur_hold) else $error("current code moved");
	property p_filter; $rose(pump_boost) && quiet |-> hr_run >= 32'(FILTER_LIMIT); endproperty
	a_filter: assert property (p_filter) else $error("boost on short need");
	property p_mask; $rose(pump_boost) && quiet |-> mhr_run >= 32'(FILTER_LIMIT); endproperty
	a_mask: assert property (p_mask) else $error("boost on ignored output");
	property p_drop;
		$fell(pump_boost) && quiet && pump_enable |->
			ok_run >= 32'(FILTER_LIMIT) || dark_run >= 32'(IDLE_LIMIT - 4);
	endproperty
	a_drop: assert property (p_drop) else $error("boost dropped early");
	property p_sda; scl_hi >= 32'd4 |-> $stable(sda_oe_n) && !sda_out; endproperty
	a_sda: assert property (p_sda) else $error("data drive moved while clock high");
	property p_step; $fell(led_pwm[0]) && quiet |=> (!led_pwm[0]) [*8]; endproperty
	a_step: assert property (p_step) else $error("pwm step too short");
	c_rise: cover property ($rose(pump_boost) && quiet);
	c_fall: cover property ($fell(pump_boost) && quiet);
	c_red: cover property ($rose(red_on_supply));
	c_pwm: cover property ($fell(led_pwm[0]) && quiet);
endmodule
bind lpc_top lpc_top_chk #(.IDLE_LIMIT(IDLE_LIMIT), .FILTER_LIMIT(FILTER_LIMIT)) chk_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.low_headroom(low_headroom), .supply_ok(supply_ok), .led_pwm(led_pwm),
	.led_current(led_current), .pump_enable(pump_enable), .pump_boost(pump_boost),
	.red_on_supply(red_on_supply));
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the LED pump and PWM control top level.
// Acts as serial bus master; the far-side model supplies the monitor flags.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import lpc_pkg::*;
	localparam int IDLE_SIM = 2000;
	localparam int FILT_SIM = 8;
	localparam logic [6:0] DEV = DEV_ADDR_BASE | 7'h01;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic [1:0] addr_sel = 2'h1;
	logic [2:0] need = 3'h0;
	int lo_cnt = 0;
	logic sda_out, sda_oe_n, pump_enable, pump_boost, red_on_supply;
	logic [2:0] low_headroom, supply_ok, led_pwm;
	logic [7:0] led_current [3];
	wire logic sda_w;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	// ------------------------------------------------------------
	// Design and far side
	// ------------------------------------------------------------
	// Open-drain data line with a pull-up: any party driving low wins.
	assign sda_w = sda_m & (sda_oe_n | sda_out);
	lpc_top #(.IDLE_LIMIT(IDLE_SIM), .FILTER_LIMIT(FILT_SIM)) uut (.sys_clk(sys_clk),
		.rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.addr_sel(addr_sel), .low_headroom(low_headroom), .supply_ok(supply_ok),
		.led_pwm(led_pwm), .led_current(led_current), .pump_enable(pump_enable),
		.pump_boost(pump_boost), .red_on_supply(red_on_supply));
	lpc_led_model leds (.need(need), .pump_boost(pump_boost), .low_headroom(low_headroom),
		.supply_ok(supply_ok));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (!pump_boost) lo_cnt <= lo_cnt + 1;
	end
	// ------------------------------------------------------------
	// Helpers and serial master
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic put_bit(input logic b);
		scl <= 1'b0;
		tick(8);
		sda_m <= b;
		tick(8);
		scl <= 1'b1;
		tick(8);
	endtask
	task automatic get_bit(output logic b);
		put_bit(1'b1);
		b = sda_w;
	endtask
	task automatic put_byte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(a);
		chk("ack", a, 1'b0);
	endtask
	task automatic bus_start();
		put_bit(1'b1);
		sda_m <= 1'b0;
		tick(8);
	endtask
	task automatic bus_stop();
		put_bit(1'b0);
		sda_m <= 1'b1;
		tick(8);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_start();
		put_byte({DEV, 1'b0});
		put_byte(a);
		put_byte(d);
		bus_stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus_start();
		put_byte({DEV, 1'b0});
		put_byte(a);
		bus_start();
		put_byte({DEV, 1'b1});
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(1'b1);
		bus_stop();
	endtask
	task automatic wait_boost(input logic v, input int lim, input string what);
		int n;
		n = 0;
		while (pump_boost !== v && n < lim) begin
			tick(1);
			n++;
		end
		chk(what, pump_boost, v);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] d;
		chk("pump_enable", pump_enable, 1'b0);
		chk("red_on_supply", red_on_supply, 1'b0);
		for (int i = 0; i < 3; i++) chk("led_current", led_current[i], CURRENT_RST);
		rd(REG_CONFIG, d);
		chk("config", d, CONFIG_RST);
		wr(REG_CURRENT_G, 8'hFF);
		chk("full scale", led_current[1], 8'hFF);
		rd(8'h0A, d);
		chk("unmapped", d, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_modes();
		logic [7:0] d;
		logic [1:0] m;
		for (int i = 1; i < 4; i++) begin
			m = 2'(i % 3);
			wr(REG_CONFIG, 8'(m) << GAIN_SEL_LO);
			chk("pump_enable", pump_enable, m != GAIN_OFF);
			chk("pump_boost", pump_boost, m == GAIN_1P5X);
			rd(REG_CONFIG, d);
			chk("config", d, 8'(m) << GAIN_SEL_LO);
			rd(REG_STATUS, d);
			chk("status", d, {6'h00, m == GAIN_1P5X, m != GAIN_OFF});
		end
		$display("forced mode test done");
	endtask
	task automatic t_auto();
		int lo0;
		wr(REG_PWM_R, 8'h80);
		wr(REG_CONFIG, {3'h0, GAIN_1P5X, 3'h0});
		need <= 3'h2;
		lo0 = lo_cnt;
		wr(REG_CONFIG, {3'h0, GAIN_AUTO, 3'h0});
		chk("entry at 1x", 32'(lo_cnt != lo0), 32'h1);
		wait_boost(1'b1, 40, "boost");
		need <= 3'h0;
		wait_boost(1'b0, 40, "back to 1x");
		need <= 3'h4;
		tick(3);
		need <= 3'h0;
		tick(40);
		chk("glitch", pump_boost, 1'b0);
		need <= 3'h4;
		tick(FILT_SIM);
		chk("filtered", pump_boost, 1'b0);
		wait_boost(1'b1, 40, "boost");
		need <= 3'h0;
		wait_boost(1'b0, 40, "back to 1x");
		$display("auto test done");
	endtask
	task automatic t_red_idle();
		wr(REG_CONFIG, {3'h0, GAIN_AUTO, 3'h4});
		chk("red_on_supply", red_on_supply, 1'b1);
		need <= 3'h1;
		tick(60);
		chk("red ignored", pump_boost, 1'b0);
		need <= 3'h3;
		wait_boost(1'b1, 40, "green watched");
		wr(REG_PWM_R, 8'h00);
		tick(IDLE_SIM - 200);
		chk("not idle yet", pump_boost, 1'b1);
		wait_boost(1'b0, 300, "idle bypass");
		chk("pump on", pump_enable, 1'b1);
		need <= 3'h0;
		$display("red and idle test done");
	endtask
	task automatic pwm_gap(input logic [7:0] en, cfg, dr, dg, input int gap);
		int t0;
		int n;
		rst_n <= 1'b0;
		tick(4);
		rst_n <= 1'b1;
		tick(4);
		wr(REG_ENABLE, en);
		wr(REG_CONFIG, cfg);
		wr(REG_PWM_R, dr);
		wr(REG_PWM_G, dg);
		chk("pwm gates", led_pwm, 3'h3);
		n = 0;
		while (led_pwm[0] === 1'b1 && n < 40000) begin
			tick(1);
			n++;
		end
		t0 = cyc;
		while (led_pwm[1] === 1'b1 && n < 80000) begin
			tick(1);
			n++;
		end
		chk("fall gap", 32'(cyc - t0), 32'(gap));
		$display("pwm test done");
	endtask
	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		tick(4);
		rst_n <= 1'b1;
		tick(4);
		t_reset();
		t_modes();
		t_auto();
		t_red_idle();
		pwm_gap(8'h80, 8'h08, 8'h68, 8'h88, 10 * int'(PWM_SLOW_DIV));
		pwm_gap(8'h00, 8'h48, 8'h08, 8'h0C, 4 * int'(PWM_FAST_DIV));
		wrap_up();
	end
	initial begin
		#800_000;
		fails++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule
`default_nettype wire
